// ===== include/bdb_pkg.sv
package bdb_pkg;
  // Byte space geometry
  localparam int PAGE_W       = 8;
  localparam int OFFSET_W     = 14;
  localparam int COUNT_W      = 14;
  localparam int IADDR_W      = 14;
  localparam int WAIT_W       = 3;
  localparam int PAGE_COUNT   = 256;
  // Data bus lanes
  localparam int BYTE_LANE_LO = 8;
  localparam int PAGE_LANE_LO = 16;
  // Transfer formats
  localparam logic [1:0] FMT_PM24   = 2'h0;
  localparam logic [1:0] FMT_DM16   = 2'h1;
  localparam logic [1:0] FMT_DM8MSB = 2'h2;
  localparam logic [1:0] FMT_DM8LSB = 2'h3;
  // Mode pins C,B,A
  localparam logic [2:0] MODE_BOOT_FULL = 3'h0;
  localparam logic [2:0] MODE_NO_BOOT   = 3'h2;
  localparam logic [2:0] MODE_BOOT_HOST = 3'h4;
  // Boot defaults
  localparam logic [COUNT_W-1:0] BOOT_COUNT = 14'h0020;
  typedef enum logic [2:0] {
    BDB_IDLE,
    BDB_BYTE,
    BDB_WAIT,
    BDB_MOVE,
    BDB_DONE
  } bdb_state_t;
endpackage

// ===== logic/bdb_byte_dma.sv
`timescale 1ns/100ps
module bdb_byte_dma
(
  // Clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        ARST_N_IN,
  // Mode straps, sampled on reset release
  input  wire logic [2:0]  MODE_IN,
  // Settings write port
  input  wire logic        CFG_WR_IN,
  input  wire logic        COUNT_WR_IN,
  input  wire logic [13:0] COUNT_DATA_IN,
  input  wire logic [1:0]  TRANSFER_FORMAT_IN,
  input  wire logic        TRANSFER_DIRECTION_IN,
  input  wire logic [13:0] INTERNAL_START_ADDRESS_IN,
  input  wire logic [13:0] EXTERNAL_BYTE_OFFSET_IN,
  input  wire logic [7:0]  BYTE_PAGE_IN,
  input  wire logic        CONTEXT_RESET_HOLD_IN,
  input  wire logic [2:0]  BYTE_WAIT_STATES_IN,
  // Status
  output logic [13:0]      WORD_COUNT_OUT,
  output logic [13:0]      EXTERNAL_BYTE_OFFSET_OUT,
  output logic [7:0]       BYTE_PAGE_OUT,
  output logic             BUSY_OUT,
  output logic             DONE_IRQ_OUT,
  output logic             HOST_MODE_OUT,
  // Core control
  input  wire logic        CORE_EXT_REQ_IN,
  output logic             CORE_HOLD_OUT,
  output logic             CORE_RESTART_OUT,
  output logic             BOOT_FROM_EXTERNAL_OUT,
  // External byte bus
  output logic             BYTE_SEL_N_OUT,
  output logic             BYTE_RD_N_OUT,
  output logic             BYTE_WR_N_OUT,
  output logic [13:0]      ADDR_OUT,
  output logic [23:0]      DATA_OUT,
  output logic [23:0]      DATA_OE_OUT,
  input  wire logic [23:0] DATA_IN,
  // Internal memory port
  output logic             MEM_REQ_OUT,
  output logic             MEM_WR_OUT,
  output logic             MEM_PM_OUT,
  output logic [13:0]      MEM_ADDR_OUT,
  output logic [23:0]      MEM_WDATA_OUT,
  input  wire logic [23:0] MEM_RDATA_IN
);

  // Bytes needed per word for a format
  function automatic logic [1:0] bytes_for(input logic [1:0] fmt);
    case (fmt)
      bdb_pkg::FMT_PM24: bytes_for = 2'h3;
      bdb_pkg::FMT_DM16: bytes_for = 2'h2;
      default:           bytes_for = 2'h1;
    endcase
  endfunction

  bdb_pkg::bdb_state_t state;
  logic [13:0] count;
  logic [13:0] ext_off;
  logic [7:0]  page;
  logic [13:0] int_addr;
  logic [1:0]  fmt;
  logic        dir_out;
  logic        hold_mode;
  logic [2:0]  wait_cfg;
  logic [2:0]  wait_cnt;
  logic [1:0]  byte_idx;
  logic [23:0] word;
  logic        rst_seen;
  logic        host_mode;
  logic        boot_pend;
  logic [1:0]  nbytes;
  logic [7:0]  out_byte;
  logic [7:0]  next_page;
  logic [13:0] next_off;

  assign nbytes = bytes_for(fmt);

  assign next_off  = ext_off + 14'h0001;
  assign next_page = (ext_off == 14'h3fff) ? page + 8'h01 : page;

  // Byte chosen for write direction, MSB first
  always_comb
  begin
    out_byte = word[7:0];
    case (fmt)
      bdb_pkg::FMT_PM24:
        out_byte = (byte_idx == 2'h0) ? word[23:16] :
                   (byte_idx == 2'h1) ? word[15:8] : word[7:0];
      bdb_pkg::FMT_DM16:
        out_byte = (byte_idx == 2'h0) ? word[15:8] : word[7:0];
      bdb_pkg::FMT_DM8MSB:
        out_byte = word[15:8];
      default:
        out_byte = word[7:0];
    endcase
  end

  // Straps caught one edge after release, not under the async reset
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      rst_seen  <= 1'b0;
      host_mode <= 1'b0;
      boot_pend <= 1'b0;
      BOOT_FROM_EXTERNAL_OUT <= 1'b0;
    end
    else
    begin
      boot_pend <= 1'b0;
      if (!rst_seen)
      begin
        rst_seen  <= 1'b1;
        host_mode <= MODE_IN[2];
        boot_pend <= (MODE_IN == bdb_pkg::MODE_BOOT_FULL) ||
                     (MODE_IN == bdb_pkg::MODE_BOOT_HOST);
        BOOT_FROM_EXTERNAL_OUT <= (MODE_IN == bdb_pkg::MODE_NO_BOOT);
      end
    end
  end

  // Settings and transfer engine
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      state     <= bdb_pkg::BDB_IDLE;
      count     <= '0;
      ext_off   <= '0;
      page      <= '0;
      int_addr  <= '0;
      fmt       <= bdb_pkg::FMT_PM24;
      dir_out   <= 1'b0;
      hold_mode <= 1'b0;
      wait_cfg  <= '0;
      wait_cnt  <= '0;
      byte_idx  <= '0;
      word      <= '0;
      DONE_IRQ_OUT     <= 1'b0;
      CORE_RESTART_OUT <= 1'b0;
    end
    else
    begin
      DONE_IRQ_OUT     <= 1'b0;
      CORE_RESTART_OUT <= 1'b0;
      case (state)
        bdb_pkg::BDB_IDLE:
        begin
          if (boot_pend)
          begin
            ext_off   <= '0;
            page      <= '0;
            int_addr  <= '0;
            fmt       <= bdb_pkg::FMT_PM24;
            dir_out   <= 1'b0;
            hold_mode <= 1'b1;
            count     <= bdb_pkg::BOOT_COUNT;
            byte_idx  <= '0;
            word      <= '0;
            state     <= bdb_pkg::BDB_BYTE;
          end
          else
          begin
            if (CFG_WR_IN)
            begin
              fmt       <= TRANSFER_FORMAT_IN;
              dir_out   <= TRANSFER_DIRECTION_IN;
              int_addr  <= INTERNAL_START_ADDRESS_IN;
              ext_off   <= EXTERNAL_BYTE_OFFSET_IN;
              page      <= BYTE_PAGE_IN;
              hold_mode <= CONTEXT_RESET_HOLD_IN;
              wait_cfg  <= BYTE_WAIT_STATES_IN;
            end
            if (COUNT_WR_IN)
            begin
              count <= COUNT_DATA_IN;
              if (COUNT_DATA_IN != 14'h0000)
              begin
                byte_idx <= '0;
                word     <= '0;
                // Write direction fetches the first word before any byte
                state    <= (CFG_WR_IN ? TRANSFER_DIRECTION_IN : dir_out) ?
                            bdb_pkg::BDB_MOVE : bdb_pkg::BDB_BYTE;
              end
            end
          end
        end
        bdb_pkg::BDB_BYTE:
        begin
          if (!CORE_EXT_REQ_IN)
          begin
            wait_cnt <= wait_cfg;
            state    <= bdb_pkg::BDB_WAIT;
          end
        end
        bdb_pkg::BDB_WAIT:
        begin
          if (wait_cnt != 3'h0)
            wait_cnt <= wait_cnt - 3'h1;
          else
          begin
            ext_off <= next_off;
            page    <= next_page;
            if (!dir_out)
              word <= {word[15:0], DATA_IN[bdb_pkg::BYTE_LANE_LO +: 8]};
            if (byte_idx == nbytes - 2'h1)
            begin
              byte_idx <= '0;
              state    <= dir_out ? bdb_pkg::BDB_DONE : bdb_pkg::BDB_MOVE;
            end
            else
            begin
              byte_idx <= byte_idx + 2'h1;
              state    <= bdb_pkg::BDB_BYTE;
            end
          end
        end
        bdb_pkg::BDB_MOVE:
        begin
          if (dir_out)
          begin
            word  <= MEM_RDATA_IN;
            state <= bdb_pkg::BDB_BYTE;
          end
          else
          begin
            int_addr <= int_addr + 14'h0001;
            state    <= bdb_pkg::BDB_DONE;
          end
        end
        bdb_pkg::BDB_DONE:
        begin
          count <= count - 14'h0001;
          word  <= '0;
          if (dir_out)
            int_addr <= int_addr + 14'h0001;
          if (count == 14'h0001)
          begin
            DONE_IRQ_OUT <= 1'b1;
            CORE_RESTART_OUT <= hold_mode;
            state <= bdb_pkg::BDB_IDLE;
          end
          else
            state <= dir_out ? bdb_pkg::BDB_MOVE : bdb_pkg::BDB_BYTE;
        end
        default:
          state <= bdb_pkg::BDB_IDLE;
      endcase
    end
  end

  // Bus drive registered from the engine state
  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      BYTE_SEL_N_OUT <= 1'b1;
      BYTE_RD_N_OUT  <= 1'b1;
      BYTE_WR_N_OUT  <= 1'b1;
      ADDR_OUT       <= '0;
      DATA_OUT       <= '0;
      DATA_OE_OUT    <= '0;
    end
    else
    begin
      if ((state == bdb_pkg::BDB_BYTE && !CORE_EXT_REQ_IN) ||
          (state == bdb_pkg::BDB_WAIT && wait_cnt != 3'h0))
      begin
        BYTE_SEL_N_OUT <= 1'b0;
        BYTE_RD_N_OUT  <= dir_out;
        BYTE_WR_N_OUT  <= !dir_out;
        // offset on address, page on upper data; host mode drives only offset bit 0 and no page
        ADDR_OUT <= host_mode ? {13'h0, ext_off[0]} : ext_off;
        DATA_OUT[23:16]    <= host_mode ? 8'h00 : page;
        DATA_OE_OUT[23:16] <= {8{!host_mode}};
        DATA_OUT[15:8]     <= out_byte;
        DATA_OE_OUT[15:8]  <= {8{dir_out}};
        DATA_OUT[7:0]      <= 8'h00;
        DATA_OE_OUT[7:0]   <= 8'h00;
      end
      else
      begin
        BYTE_SEL_N_OUT <= 1'b1;
        BYTE_RD_N_OUT  <= 1'b1;
        BYTE_WR_N_OUT  <= 1'b1;
        DATA_OE_OUT    <= '0;
      end
    end
  end

  always_comb
  begin
    MEM_REQ_OUT   = (state == bdb_pkg::BDB_MOVE);
    MEM_WR_OUT    = (state == bdb_pkg::BDB_MOVE) && !dir_out;
    MEM_PM_OUT    = (fmt == bdb_pkg::FMT_PM24);
    MEM_ADDR_OUT  = int_addr;
    case (fmt)
      bdb_pkg::FMT_PM24:   MEM_WDATA_OUT = word;
      bdb_pkg::FMT_DM16:   MEM_WDATA_OUT = {8'h00, word[15:0]};
      bdb_pkg::FMT_DM8MSB: MEM_WDATA_OUT = {8'h00, word[7:0], 8'h00};
      default:             MEM_WDATA_OUT = {16'h0000, word[7:0]};
    endcase
  end

  assign BUSY_OUT                 = (state != bdb_pkg::BDB_IDLE);
  // stall core while holding
  // Also held until straps are read, so a boot never races the core
  assign CORE_HOLD_OUT            = (BUSY_OUT && hold_mode) || boot_pend || !rst_seen;
  assign WORD_COUNT_OUT           = count;
  assign EXTERNAL_BYTE_OFFSET_OUT = ext_off;
  assign BYTE_PAGE_OUT            = page;
  assign HOST_MODE_OUT            = host_mode;

  // no byte strobe while core wants the bus starts
  a_core_priority: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state == bdb_pkg::BDB_BYTE && CORE_EXT_REQ_IN) |=> state == bdb_pkg::BDB_BYTE)
    else $error("byte access began while core held the bus");
  a_count_step: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    state == bdb_pkg::BDB_DONE |=> count == $past(count) - 14'h0001)
    else $error("word count did not step down");
  a_done_irq: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    DONE_IRQ_OUT |-> count == 14'h0000 && state == bdb_pkg::BDB_IDLE)
    else $error("interrupt without finished count");
  a_start_nonzero: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state == bdb_pkg::BDB_IDLE && !boot_pend && COUNT_WR_IN && COUNT_DATA_IN != 14'h0000)
    |=> BUSY_OUT)
    else $error("nonzero count did not start transfer");
  a_page_carry: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state == bdb_pkg::BDB_WAIT && wait_cnt == 3'h0 && ext_off == 14'h3fff)
    |=> page == $past(page) + 8'h01 && ext_off == 14'h0000)
    else $error("page did not advance on wrap");
  a_wait_stretch: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (state == bdb_pkg::BDB_BYTE && !CORE_EXT_REQ_IN && wait_cfg == 3'h2)
    |=> state == bdb_pkg::BDB_WAIT [*3])
    else $error("wait states not applied");
  a_move_single: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    state == bdb_pkg::BDB_MOVE |=> state != bdb_pkg::BDB_MOVE)
    else $error("memory move took more than one cycle");
  a_boot_load: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    boot_pend |=> count == bdb_pkg::BOOT_COUNT && hold_mode && CORE_HOLD_OUT)
    else $error("boot defaults not loaded");
  a_zero_fill: assert property (@(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
    (MEM_WR_OUT && fmt == bdb_pkg::FMT_DM8LSB) |-> MEM_WDATA_OUT[23:8] == 16'h0000)
    else $error("byte format upper bits not zero");

endmodule // bdb_byte_dma

// ===== testbench/bdb_byte_mem.sv
`timescale 1ns/100ps
module bdb_byte_mem
(
  // Clock
  input  wire logic        clk_in,
  // Byte bus from the device
  input  wire logic        sel_n_in,
  input  wire logic        rd_n_in,
  input  wire logic        wr_n_in,
  input  wire logic [13:0] addr_in,
  input  wire logic [23:0] bus_in,
  // Drive toward the bus
  output logic [23:0]      drv_out
);
  logic [29:0] log_q[$];
  int          last_low = 0;
  int          low_cnt  = 0;
  logic        sel_prev = 1'b1;
  logic [7:0]  last     = 8'h00;
  logic        tog      = 1'b0;
  logic [7:0]  rom_byte;
  function automatic logic [7:0] rom(input logic [7:0] p, input logic [13:0] o);
    return o[7:0] ^ {o[13:8], 2'h0} ^ p;
  endfunction
  assign rom_byte = rom(bus_in[23:16], addr_in);
  // byte on 15:8, page seen on 23:16
  // Idle lanes toggle so a stale byte never looks valid
  assign drv_out = {~{8{tog}}, (!sel_n_in && !rd_n_in) ? rom_byte : ~last, {8{tog}}};
  always @(posedge clk_in)
  begin
    tog      <= ~tog;
    sel_prev <= sel_n_in;
    if (!sel_n_in)
      low_cnt <= low_cnt + 1;
    else if (low_cnt != 0)
    begin
      last_low <= low_cnt;
      low_cnt  <= 0;
    end
    if (!sel_n_in && sel_prev)
      log_q.push_back({bus_in[23:16], addr_in, !wr_n_in ? bus_in[15:8] : rom_byte});
    if (!sel_n_in && !rd_n_in)
      last <= rom_byte;
  end
endmodule // bdb_byte_mem

// ===== testbench/bdb_byte_dma_test.sv
`timescale 1ns/100ps
module bdb_byte_dma_test;
  logic        clk = 1'b0, arst_n = 1'b0, cfg_wr = 1'b0, cnt_wr = 1'b0, dir = 1'b0;
  logic        hold = 1'b0, core_req = 1'b0, sel_prev = 1'b1, req_prev = 1'b0;
  logic [2:0]  mode = 3'h0, ws = 3'h0;
  logic [1:0]  fmt = 2'h0;
  logic [13:0] cnt = 14'h0, ia = 14'h0, off = 14'h0, wc, off_o, addr, m_addr;
  logic [7:0]  page = 8'h0, page_o;
  logic        busy, irq_o, host, c_hold, c_rst, boot_ext, sel_n, rd_n, wr_n, m_req, m_wr, m_pm;
  logic [23:0] dout, doe, bus, drv, m_wd, m_rd;
  logic [38:0] mq[$];
  int          bad_count = 0, cmp_count = 0, mreq, irq, rst, hold_seen, viol;
  always #10 clk = ~clk;
  assign bus  = (dout & doe) | (drv & ~doe);
  assign m_rd = {m_addr[7:0], m_addr[7:0] ^ 8'hc3, ~m_addr[7:0]};
  bdb_byte_dma bdb_byte_dma_i (.REF_CLK_IN(clk), .ARST_N_IN(arst_n), .MODE_IN(mode),
    .CFG_WR_IN(cfg_wr), .COUNT_WR_IN(cnt_wr), .COUNT_DATA_IN(cnt), .TRANSFER_FORMAT_IN(fmt),
    .TRANSFER_DIRECTION_IN(dir), .INTERNAL_START_ADDRESS_IN(ia), .EXTERNAL_BYTE_OFFSET_IN(off),
    .BYTE_PAGE_IN(page), .CONTEXT_RESET_HOLD_IN(hold), .BYTE_WAIT_STATES_IN(ws),
    .WORD_COUNT_OUT(wc), .EXTERNAL_BYTE_OFFSET_OUT(off_o), .BYTE_PAGE_OUT(page_o),
    .BUSY_OUT(busy), .DONE_IRQ_OUT(irq_o), .HOST_MODE_OUT(host), .CORE_EXT_REQ_IN(core_req),
    .CORE_HOLD_OUT(c_hold), .CORE_RESTART_OUT(c_rst), .BOOT_FROM_EXTERNAL_OUT(boot_ext),
    .BYTE_SEL_N_OUT(sel_n), .BYTE_RD_N_OUT(rd_n), .BYTE_WR_N_OUT(wr_n), .ADDR_OUT(addr),
    .DATA_OUT(dout), .DATA_OE_OUT(doe), .DATA_IN(bus), .MEM_REQ_OUT(m_req), .MEM_WR_OUT(m_wr),
    .MEM_PM_OUT(m_pm), .MEM_ADDR_OUT(m_addr), .MEM_WDATA_OUT(m_wd), .MEM_RDATA_IN(m_rd));
  bdb_byte_mem bdb_byte_mem_i (.clk_in(clk), .sel_n_in(sel_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .addr_in(addr), .bus_in(bus), .drv_out(drv));
  function automatic logic [7:0] rom(input logic [7:0] p, input logic [13:0] o);
    return o[7:0] ^ {o[13:8], 2'h0} ^ p;
  endfunction
  // Side monitor: memory port words, pulses, strobe starts under core request
  always @(posedge clk)
  begin
    sel_prev <= sel_n;
    req_prev <= core_req;
    if (m_req === 1'b1) mreq <= mreq + 1;
    if (m_req === 1'b1 && m_wr === 1'b1) mq.push_back({m_pm, m_addr, m_wd});
    if (irq_o === 1'b1) irq <= irq + 1;
    if (c_rst === 1'b1) rst <= rst + 1;
    if (c_hold === 1'b1) hold_seen <= 1;
    if (sel_n === 1'b0 && sel_prev && req_prev) viol <= viol + 1;
  end
  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    $display("Checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic clear_logs;
    bdb_byte_mem_i.log_q.delete();
    mq.delete();
    mreq = 0; irq = 0; rst = 0; hold_seen = 0; viol = 0;
  endtask
  task automatic do_reset(input logic [2:0] m);
    arst_n = 1'b0;
    mode = m;
    repeat (8) @(posedge clk);
    #2 arst_n = 1'b1;
    clear_logs();
    repeat (2) @(posedge clk);
    #2;
  endtask
  task automatic start(input logic [1:0] f, input logic d, input logic h, input logic [2:0] w,
                       input logic [7:0] p, input logic [13:0] o, input logic [13:0] a,
                       input logic [13:0] c);
    @(posedge clk);
    #2;
    clear_logs();
    fmt = f; dir = d; hold = h; ws = w; page = p; off = o; ia = a; cnt = c;
    cfg_wr = 1'b1; cnt_wr = 1'b1;
    @(posedge clk);
    #2 cfg_wr = 1'b0; cnt_wr = 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
    if (n >= 3000)
    begin
      chk("idle timeout", 40'h0, 40'h1);
      final_report();
    end
    repeat (3) @(posedge clk);
    #2;
  endtask
  task automatic t_boot;
    int i;
    do_reset(bdb_pkg::MODE_BOOT_FULL);
    chk("boot busy", 1, busy);
    chk("boot hold", 1, c_hold);
    wait_idle();
    chk("boot bytes", 96, bdb_byte_mem_i.log_q.size());
    chk("boot words", 32, mreq);
    for (i = 0; i < 3; i++) chk("boot addr", i, bdb_byte_mem_i.log_q[i][29:8]);
    chk("pm word", {1'b1, 14'h0, rom(8'h0, 14'h0), rom(8'h0, 14'h1), rom(8'h0, 14'h2)}, mq[0]);
    chk("boot irq", 1, irq);
    chk("boot restart", 1, rst);
    chk("boot count", 0, wc);
    $display("t_boot done");
  endtask
  task automatic t_nob;
    do_reset(bdb_pkg::MODE_NO_BOOT);
    chk("ext boot", 1, boot_ext);
    chk("nob busy", 0, busy);
    start(bdb_pkg::FMT_DM8LSB, 1'b0, 1'b0, 3'h0, 8'h12, 14'h3fff, 14'h0100, 14'h0);
    @(posedge clk);
    #2;
    chk("zero count busy", 0, busy);
    start(bdb_pkg::FMT_DM8LSB, 1'b0, 1'b0, 3'h0, 8'h12, 14'h3fff, 14'h0100, 14'h2);
    wait_idle();
    chk("wrap first", {8'h12, 14'h3fff}, bdb_byte_mem_i.log_q[0][29:8]);
    chk("wrap second", {8'h13, 14'h0}, bdb_byte_mem_i.log_q[1][29:8]);
    chk("lsb word", {1'b0, 14'h0100, 16'h0, rom(8'h12, 14'h3fff)}, mq[0]);
    chk("page out", 8'h13, page_o);
    chk("off out", 14'h1, off_o);
    chk("nob irq", 1, irq);
    chk("nob restart", 0, rst);
    start(bdb_pkg::FMT_DM8MSB, 1'b0, 1'b0, 3'h0, 8'h00, 14'h5, 14'h0020, 14'h1);
    wait_idle();
    chk("msb word", {1'b0, 14'h0020, 8'h0, rom(8'h0, 14'h5), 8'h0}, mq[0]);
    $display("t_nob done");
  endtask
  task automatic t_wr;
    core_req = 1'b1;
    start(bdb_pkg::FMT_DM16, 1'b1, 1'b1, 3'h2, 8'h40, 14'h0010, 14'h0033, 14'h2);
    repeat (10) @(posedge clk);
    #2;
    chk("core wins", 0, bdb_byte_mem_i.log_q.size());
    chk("core held", 1, c_hold);
    core_req = 1'b0;
    wait_idle();
    chk("wr byte0", {8'h40, 14'h10, 8'h33 ^ 8'hc3}, bdb_byte_mem_i.log_q[0]);
    chk("wr byte1", {8'h40, 14'h11, ~8'h33}, bdb_byte_mem_i.log_q[1]);
    chk("wr bytes", 4, bdb_byte_mem_i.log_q.size());
    chk("wr byte3", {8'h40, 14'h13}, bdb_byte_mem_i.log_q[3][29:8]);
    chk("strobe len", 3, bdb_byte_mem_i.last_low);
    chk("no steal", 0, viol);
    chk("wr restart", 1, rst);
    chk("wr irq", 1, irq);
    $display("t_wr done");
  endtask
  task automatic t_host;
    int i;
    do_reset(bdb_pkg::MODE_BOOT_HOST);
    repeat (20) @(posedge clk);
    #2;
    chk("host mode", 1, host);
    chk("host busy", 1, busy);
    for (i = 0; i < bdb_byte_mem_i.log_q.size(); i++)
      chk("host addr", i % 2, bdb_byte_mem_i.log_q[i][21:8]);
    do_reset(bdb_pkg::MODE_NO_BOOT);
    chk("rerun idle", 0, busy);
    chk("rerun hold", 0, c_hold);
    $display("t_host done");
  endtask
  initial
  begin
    t_boot();
    t_nob();
    t_wr();
    t_host();
    final_report();
  end
endmodule // bdb_byte_dma_test
